// ---- core/cscr_pkg.sv ----
package cscr_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int WD_UNIT_S = 1; // watchdog counts whole seconds
	localparam int WD_SEC_CYCLES = CLK_HZ * WD_UNIT_S;
	localparam int RST_PULSE_US = 1000; // length of the watchdog reset pulse
	localparam int RST_PULSE_CYCLES = (CLK_HZ / 1_000_000) * RST_PULSE_US;
	localparam int STRAP_SETTLE = 3; // cycles before straps are trusted
	localparam logic [22:0] REF_KHZ = 23'h37ee; // 14318 kHz reference

	// ------------------------------------------------------------
	// register offsets and storage indexes
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_OUT_EN = 5'h06;
	localparam logic [4:0] OFS_MISC = 5'h07;
	localparam logic [4:0] OFS_SKEW = 5'h08;
	localparam logic [4:0] OFS_STOP = 5'h09;
	localparam logic [4:0] OFS_WDOG = 5'h0a;
	localparam logic [4:0] OFS_MNH = 5'h0b;
	localparam logic [4:0] OFS_NLO = 5'h0c;
	localparam logic [4:0] OFS_SPR = 5'h0d;
	localparam logic [4:0] OFS_DIV = 5'h0e;
	localparam logic [4:0] OFS_ID_LO = 5'h0f;
	localparam logic [4:0] OFS_ID_HI = 5'h10;
	localparam int NCFG = 9;
	localparam int I_OUT_EN = 0;
	localparam int I_MISC = 1;
	localparam int I_SKEW = 2;
	localparam int I_STOP = 3;
	localparam int I_WDOG = 4;
	localparam int I_MNH = 5;
	localparam int I_NLO = 6;
	localparam int I_SPR = 7;
	localparam int I_DIV = 8;

	// ------------------------------------------------------------
	// field positions, reset values, writable masks
	// ------------------------------------------------------------
	localparam int WD_EN_BIT = 7;
	localparam int WD_FLAG_BIT = 6;
	localparam int MN_MODE_BIT = 7;
	localparam int FREE_RUN_BIT = 6;
	localparam logic [NCFG-1:0][7:0] CFG_RST =
		{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'he0, 8'h04, 8'hff, 8'hff};
	localparam logic [NCFG-1:0][7:0] CFG_WMASK =
		{8'hff, 8'hff, 8'hff, 8'hff, 8'hbf, 8'he0, 8'h07, 8'hff, 8'hff};

	// identification values are arbitrary
	localparam logic [7:0] ID_LOW = 8'h5a;
	localparam logic [3:0] ID_HIGH = 4'h3;
	localparam logic [3:0] VERSION = 4'h2;

	// cpu/sdram/pci vco divisors per ratio code, entry 15 first
	localparam logic [15:0][11:0] RATIO_TBL = {12'h664, 12'h663, 12'h662, 12'h642,
		12'h632, 12'h463, 12'h443, 12'h434, 12'h433, 12'h345, 12'h344, 12'h335,
		12'h334, 12'h333, 12'h235, 12'h225};
	// graphics divisor per code, zero marks an undefined code
	localparam logic [7:0][3:0] AGP_TBL =
		{4'ha, 4'h0, 4'h0, 4'h4, 4'h8, 4'h6, 4'h5, 4'h3};

	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_CNT, ST_WR, ST_RD,
		ST_SKIP} cscr_fsm_t;

	typedef struct packed {
		logic [1:0] gfx_en;
		logic [5:0] bus_en;
		logic sel_low_en;
		logic fixed48_en;
		logic intr_en;
		logic sel_24;
		logic intr_half;
		logic [1:0] ref_en;
		logic [2:0] skew;
		logic host1_stoppable;
		logic host1_run;
		logic mn_mode;
		logic [4:0] vco_m;
		logic [8:0] vco_n;
		logic [1:0] test;
		logic [3:0] spread_up;
		logic [3:0] spread_dn;
		logic [3:0] cpu_div;
		logic [3:0] sdram_div;
		logic [3:0] pci_div;
		logic [3:0] agp_div;
		logic agp_valid;
		logic [22:0] vco_khz;
	} cscr_ctrl_t;

	typedef struct packed {
		cscr_fsm_t fsm;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [4:0] idx;
		logic ack_pend;
		logic [7:0] tx;
		logic sda_oe;
		logic [NCFG-1:0][7:0] cfg;
		logic [4:0] strap;
		logic [1:0] strap_wait;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [4:0] strap_s1;
		logic [4:0] strap_s2;
		logic [4:0] halt_s1;
		logic [4:0] halt_s2;
		logic [31:0] sec_cnt;
		logic [31:0] pulse_cnt;
		logic [5:0] wd_left;
		logic wd_flag;
		logic sys_rst_n;
		cscr_ctrl_t ctrl;
	} cscr_state_t;

endpackage : cscr_pkg

// ---- core/cscr_top.sv ----
`timescale 1ns/10ps
// Behaviour
// RL1: each output enable bit runs its clock when 1; all enables power up 1
// RL2: enable bits 7/6 graphics clocks 1/0, bits 5..1 bus clocks, bit 0 free clock
// RL3: misc bits gate low-freq, fixed 48, interrupt clock, two references; bit 2 reserved
// RL4: misc bit 4 picks 24 MHz when 1, 48 MHz when 0; powers up 1
// RL5: misc bit 3 halves the interrupt clock versus bus clock; powers up 1
// RL6: skew code in bits 2..0 powers up 100; bits 7..3 show latched straps
// RL7: stop bit 6 lets host clock 1 halt on its stop input; bits 4..0 show stop levels
// RL8: watchdog bit 7 starts the timer when 1, stops it when 0; powers up 0
// RL9: watchdog bits 5..0 hold the timeout in seconds, powering up zero
// RL10: watchdog bit 6 is a read-only timeout flag, writes ignored
// RL11: M in bits 4..0; N bit 8 in bit 7, N low byte in next register
// RL12: divider register bits 6 and 5 are test bits, power up 1 and 0
// RL13: spread register holds up count 7..4 and down count 3..0, zero at power-up
// RL14: divisor bit 7 picks table frequency at 0, M/N with ratios at 1
// RL15: in M/N mode vco equals reference times (N plus four) over M
// RL16: divisor bits 6..3 pick cpu/sdram/pci divisors from a sixteen-entry table
// RL17: graphics code maps 0..4 and 7 to divisors; codes 5 and 6 undefined
// RL18: two read-only identity registers, low nibble of the second is version
// RL19: registers take power-up values only on true power-up reset
// RL20: command and count bytes are acked and ignored; data starts at register 0
// RL21: an expired enabled watchdog sets its flag and pulses the reset output low
module cscr_top #(
	parameter logic [6:0] DEV_ADDR = 7'h4a,
	parameter int WD_SEC_CYCLES = cscr_pkg::WD_SEC_CYCLES,
	parameter int RST_PULSE_CYCLES = cscr_pkg::RST_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic graphics_select_strap,
	input wire logic freq_select_strap_3,
	input wire logic freq_select_strap_2,
	input wire logic freq_select_strap_1,
	input wire logic freq_select_strap_0,
	input wire logic graphics_clock_halt_n,
	input wire logic host_clock_halt_n,
	input wire logic local_bus_clock_halt_n,
	input wire logic memory_clock_halt_n,
	input wire logic power_down_n,
	output cscr_pkg::cscr_ctrl_t ctrl,
	output logic system_reset_n
);

	// ------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------
	logic link_bit_r;

	// data bit caught on the rising serial clock; it stays put for the whole
	// high phase, long enough for the core to see the synchronised edge first.
	// the core reads this flop only in the cycle after a synchronised rising
	// edge, when it has been stable for at least one core clock, so that edge
	// qualifies the crossing and the data bit needs no synchroniser of its own
	always_ff @(posedge scl)
	begin
		link_bit_r <= sda_in;
	end

	// ------------------------------------------------------------
	// core domain helpers
	// ------------------------------------------------------------
	cscr_pkg::cscr_state_t s_r;
	cscr_pkg::cscr_state_t s_nxt;

	// turn stored configuration into the outputs that steer the clock tree;
	// one function serves both the reset branch and the next-state logic, so
	// the outputs can never disagree with the stored bits after reset
	function automatic cscr_pkg::cscr_ctrl_t decode(
		input logic [cscr_pkg::NCFG-1:0][7:0] c,
		input logic host_halt_n
	);
		cscr_pkg::cscr_ctrl_t d;
		logic [11:0] r;
		logic [22:0] num;
		d = '0;
		d.gfx_en = c[cscr_pkg::I_OUT_EN][7:6]; // RL2
		d.bus_en = c[cscr_pkg::I_OUT_EN][5:0]; // RL1
		d.sel_low_en = c[cscr_pkg::I_MISC][7]; // RL3
		d.fixed48_en = c[cscr_pkg::I_MISC][6];
		d.intr_en = c[cscr_pkg::I_MISC][5];
		d.sel_24 = c[cscr_pkg::I_MISC][4]; // RL4
		d.intr_half = c[cscr_pkg::I_MISC][3]; // RL5
		d.ref_en = c[cscr_pkg::I_MISC][1:0]; // RL3
		d.skew = c[cscr_pkg::I_SKEW][2:0]; // RL6
		d.host1_stoppable = c[cscr_pkg::I_STOP][cscr_pkg::FREE_RUN_BIT]; // RL7
		d.host1_run = ~(d.host1_stoppable & ~host_halt_n); // RL7
		d.vco_m = c[cscr_pkg::I_MNH][4:0]; // RL11
		d.vco_n = {c[cscr_pkg::I_MNH][7], c[cscr_pkg::I_NLO]}; // RL11
		d.test = c[cscr_pkg::I_MNH][6:5]; // RL12
		d.spread_up = c[cscr_pkg::I_SPR][7:4]; // RL13
		d.spread_dn = c[cscr_pkg::I_SPR][3:0]; // RL13
		d.mn_mode = c[cscr_pkg::I_DIV][cscr_pkg::MN_MODE_BIT]; // RL14
		// the ratio code is looked up even in table mode, the graphics code only in M/N mode; only the
		// result is masked, which keeps the lookup path short
		r = cscr_pkg::RATIO_TBL[c[cscr_pkg::I_DIV][6:3]]; // RL16
		num = 23'(cscr_pkg::REF_KHZ * (23'(d.vco_n) + 23'h4)); // RL15
		// in table mode the divisors, graphics divisor and vco frequency stay zero
		if (d.mn_mode)
		begin
			d.cpu_div = r[11:8];
			d.sdram_div = r[7:4];
			d.pci_div = r[3:0];
			d.agp_div = cscr_pkg::AGP_TBL[c[cscr_pkg::I_DIV][2:0]]; // RL17
			d.agp_valid = (d.agp_div != 4'h0); // RL17
			d.vco_khz = (d.vco_m == 5'h0) ? 23'h0 : 23'(num / 23'(d.vco_m)); // RL15
		end
		return d;
	endfunction : decode

	// value returned for a register read; read-only fields show live or
	// latched pin levels, and unmapped offsets read as zero so a host that
	// walks past the last register sees a harmless pattern
	function automatic logic [7:0] rd_val(input cscr_pkg::cscr_state_t s,
		input logic [4:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			cscr_pkg::OFS_OUT_EN: v = s.cfg[cscr_pkg::I_OUT_EN];
			cscr_pkg::OFS_MISC: v = s.cfg[cscr_pkg::I_MISC];
			cscr_pkg::OFS_SKEW: v = {s.strap, s.cfg[cscr_pkg::I_SKEW][2:0]}; // RL6
			cscr_pkg::OFS_STOP: v = {s.cfg[cscr_pkg::I_STOP][7:5], s.halt_s2}; // RL7
			cscr_pkg::OFS_WDOG: // RL10
			begin
				v = s.cfg[cscr_pkg::I_WDOG];
				v[cscr_pkg::WD_FLAG_BIT] = s.wd_flag;
			end
			cscr_pkg::OFS_MNH: v = s.cfg[cscr_pkg::I_MNH];
			cscr_pkg::OFS_NLO: v = s.cfg[cscr_pkg::I_NLO];
			cscr_pkg::OFS_SPR: v = s.cfg[cscr_pkg::I_SPR];
			cscr_pkg::OFS_DIV: v = s.cfg[cscr_pkg::I_DIV];
			cscr_pkg::OFS_ID_LO: v = cscr_pkg::ID_LOW; // RL18
			cscr_pkg::OFS_ID_HI: v = {cscr_pkg::ID_HIGH, cscr_pkg::VERSION}; // RL18
			default: v = 8'h00;
		endcase
		return v;
	endfunction : rd_val

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic [7:0] byte_in;
	logic wd_restart;
	logic wd_en;
	logic wd_expire;
	logic [4:0] widx;

	// edge detectors read only the second sync stage and its delayed copy;
	// start and stop are data edges while the clock is high, so the host
	// must move data only while the clock is low
	assign scl_rise = s_r.scl_s[1] & ~s_r.scl_s[2];
	assign scl_fall = ~s_r.scl_s[1] & s_r.scl_s[2];
	assign start_ev = s_r.scl_s[1] & s_r.scl_s[2] & s_r.sda_s[2] & ~s_r.sda_s[1];
	assign stop_ev = s_r.scl_s[1] & s_r.scl_s[2] & ~s_r.sda_s[2] & s_r.sda_s[1];
	assign byte_in = {s_r.sh[6:0], link_bit_r};
	assign widx = 5'(s_r.idx - cscr_pkg::OFS_OUT_EN);

	// whole next state in one place; anything not touched below keeps its
	// value, which is how the configuration survives between transfers
	always_comb
	begin
		s_nxt = s_r;
		wd_restart = 1'b0;
		// two-stage synchronisers for every pin read by the core
		s_nxt.scl_s = {s_r.scl_s[1:0], scl};
		s_nxt.sda_s = {s_r.sda_s[1:0], sda_in};
		s_nxt.strap_s1 = {graphics_select_strap, freq_select_strap_3,
			freq_select_strap_2, freq_select_strap_1, freq_select_strap_0};
		s_nxt.strap_s2 = s_r.strap_s1;
		s_nxt.halt_s1 = {graphics_clock_halt_n, host_clock_halt_n,
			local_bus_clock_halt_n, memory_clock_halt_n, power_down_n};
		s_nxt.halt_s2 = s_r.halt_s1;

		// straps are caught once, after the synchronisers have filled;
		// later pin changes are ignored until the next power-up
		if (s_r.strap_wait != 2'(cscr_pkg::STRAP_SETTLE))
		begin
			s_nxt.strap_wait = 2'(s_r.strap_wait + 2'h1);
			s_nxt.strap = s_r.strap_s2; // RL6
		end

		// serial protocol: start and stop override any bit in flight;
		// a byte cut short by start or stop is dropped, since nothing is
		// stored before its eighth bit has arrived
		if (start_ev)
		begin
			s_nxt.fsm = cscr_pkg::ST_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.idx = 5'h00; // RL20
			s_nxt.ack_pend = 1'b0;
			s_nxt.sda_oe = 1'b0;
		end
		else if (stop_ev)
		begin
			s_nxt.fsm = cscr_pkg::ST_IDLE;
			s_nxt.sda_oe = 1'b0;
		end
		else if (scl_rise && s_r.fsm != cscr_pkg::ST_IDLE)
		begin
			if (s_r.cnt == 4'h8)
			begin
				// acknowledge slot; in a read a high level is the host's nack
				// the byte pointer moves only when the host asks for another byte
				s_nxt.cnt = 4'h0;
				if (s_r.fsm == cscr_pkg::ST_RD)
				begin
					if (link_bit_r)
						s_nxt.fsm = cscr_pkg::ST_SKIP;
					else
					begin
						s_nxt.tx = rd_val(s_r, s_r.idx);
						s_nxt.idx = 5'(s_r.idx + 5'h01);
					end
				end
			end
			else
			begin
				s_nxt.sh = byte_in;
				s_nxt.cnt = 4'(s_r.cnt + 4'h1);
				if (s_r.cnt == 4'h7)
				begin
					s_nxt.ack_pend = 1'b1;
					case (s_r.fsm)
						cscr_pkg::ST_ADDR:
						begin
							if (byte_in[7:1] == DEV_ADDR)
								s_nxt.fsm = byte_in[0] ? cscr_pkg::ST_RD : cscr_pkg::ST_CMD;
							else
							begin
								s_nxt.fsm = cscr_pkg::ST_SKIP;
								s_nxt.ack_pend = 1'b0;
							end
						end
						cscr_pkg::ST_CMD: s_nxt.fsm = cscr_pkg::ST_CNT; // RL20
						cscr_pkg::ST_CNT: s_nxt.fsm = cscr_pkg::ST_WR; // RL20
						cscr_pkg::ST_WR:
						begin
							// only the stored, writable bits take the byte;
							// offsets outside the stored range are acked and dropped
							if (s_r.idx >= cscr_pkg::OFS_OUT_EN && s_r.idx <= cscr_pkg::OFS_DIV)
							begin
								s_nxt.cfg[widx] = (s_r.cfg[widx] & ~cscr_pkg::CFG_WMASK[widx])
									| (byte_in & cscr_pkg::CFG_WMASK[widx]); // RL10
								wd_restart = (s_r.idx == cscr_pkg::OFS_WDOG);
							end
							s_nxt.idx = 5'(s_r.idx + 5'h01); // RL20
						end
						default: s_nxt.ack_pend = 1'b0;
					endcase
				end
			end
		end
		else if (scl_fall)
		begin
			// change the drive only while the clock is low so start and stop stay clean;
			// the level set here stands until the next falling edge, start or stop
			if (s_r.fsm == cscr_pkg::ST_RD && s_r.cnt != 4'h8)
				s_nxt.sda_oe = ~s_r.tx[3'(3'h7 - s_r.cnt[2:0])];
			else if (s_r.cnt == 4'h8)
				s_nxt.sda_oe = s_r.ack_pend;
			else
				s_nxt.sda_oe = 1'b0;
		end

		// watchdog: a write to its register restarts the count; a zero count
		// behaves like one second, so the timer can never expire instantly
		wd_en = s_nxt.cfg[cscr_pkg::I_WDOG][cscr_pkg::WD_EN_BIT]; // RL8
		// expiry is judged on the registered state, so a restart written in
		// the same cycle cannot swallow it
		wd_expire = s_r.cfg[cscr_pkg::I_WDOG][cscr_pkg::WD_EN_BIT]
			&& (s_r.sec_cnt == 32'(WD_SEC_CYCLES - 1)) && (s_r.wd_left <= 6'h01);
		if (wd_restart)
			s_nxt.wd_flag = 1'b0;
		if (!wd_en || wd_restart)
		begin
			s_nxt.sec_cnt = 32'h0000_0000;
			s_nxt.wd_left = s_nxt.cfg[cscr_pkg::I_WDOG][5:0]; // RL9
		end
		else if (s_r.sec_cnt == 32'(WD_SEC_CYCLES - 1))
		begin
			// one second gone: count down, reload after the last one
			s_nxt.sec_cnt = 32'h0000_0000;
			if (s_r.wd_left <= 6'h01)
				s_nxt.wd_left = s_r.cfg[cscr_pkg::I_WDOG][5:0];
			else
				s_nxt.wd_left = 6'(s_r.wd_left - 6'h01);
		end
		else
			s_nxt.sec_cnt = 32'(s_r.sec_cnt + 32'h0000_0001);
		// expiry wins over a clear in the same cycle
		if (wd_expire)
		begin
			s_nxt.wd_flag = 1'b1; // RL21
			s_nxt.pulse_cnt = 32'(RST_PULSE_CYCLES); // RL21
		end
		// the pulse counts down on its own; a fresh expiry restarts it
		if (s_r.pulse_cnt != 32'h0000_0000 && s_nxt.pulse_cnt == s_r.pulse_cnt)
			s_nxt.pulse_cnt = 32'(s_r.pulse_cnt - 32'h0000_0001);
		s_nxt.sys_rst_n = (s_nxt.pulse_cnt == 32'h0000_0000); // RL21

		s_nxt.ctrl = decode(s_nxt.cfg, s_r.halt_s2[3]);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// only the power-up reset loads the documented defaults; the watchdog
	// pulse leaves the configuration alone, so software settings survive it.
	// the edge history starts at the idle level so no false edge follows reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
			s_r.fsm <= cscr_pkg::ST_IDLE;
			s_r.scl_s <= 3'h7;
			s_r.sda_s <= 3'h7;
			s_r.cfg <= cscr_pkg::CFG_RST; // RL19
			s_r.sys_rst_n <= 1'b1;
			s_r.ctrl <= decode(cscr_pkg::CFG_RST, 1'b1);
		end
		else
			s_r <= s_nxt;
	end

	// open-drain data pin: only ever pulled low,
	// so the enable alone carries the data value
	assign sda_out = 1'b0;
	assign sda_oe = s_r.sda_oe;
	assign ctrl = s_r.ctrl;
	assign system_reset_n = s_r.sys_rst_n;

endmodule : cscr_top

// ---- test/cscr_top_chk.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// port checker
// ----------------------------------------
module cscr_top_chk #(
	parameter int RST_PULSE_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_oe,
	input wire logic host_clock_halt_n,
	input wire cscr_pkg::cscr_ctrl_t ctrl,
	input wire logic system_reset_n
);
	logic [31:0] low_cnt_r;
	logic [31:0] low_cnt_nxt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// length of the current watchdog reset pulse, in core cycles
	always_comb low_cnt_nxt = system_reset_n ? 32'h0000_0000 : low_cnt_r + 32'h0000_0001;
	always_ff @(posedge clk) low_cnt_r <= low_cnt_nxt;
	// stop input held long enough to pass the two-flop synchroniser
	sequence s_halt_held;
		(ctrl.host1_stoppable && !host_clock_halt_n) [*5];
	endsequence
	a_pwrup_vals: assert property ($rose(rst_n) |-> ctrl.gfx_en == 2'h3 && ctrl.bus_en == 6'h3f &&
		ctrl.sel_low_en && ctrl.fixed48_en && ctrl.intr_en && ctrl.sel_24 && ctrl.intr_half &&
		ctrl.ref_en == 2'h3 && ctrl.skew == 3'h4 && ctrl.test == 2'h2 && !ctrl.mn_mode)
		else $error("control outputs differ from power-up values");
	a_pulse_len: assert property ($rose(system_reset_n) |-> low_cnt_r == RST_PULSE_CYCLES)
		else $error("watchdog reset pulse has wrong length");
	a_table_zero: assert property (!ctrl.mn_mode |-> ctrl.cpu_div == 4'h0 && ctrl.vco_khz == 23'h0)
		else $error("divisors active in table mode");
	a_vco_calc: assert property (ctrl.mn_mode && ctrl.vco_m != 5'h00 |-> ctrl.vco_khz ==
		23'(32'h0000_37ee * (32'(ctrl.vco_n) + 32'h0000_0004) / 32'(ctrl.vco_m)))
		else $error("vco frequency does not follow m and n");
	a_free_run: assert property (!ctrl.host1_stoppable [*2] |-> ctrl.host1_run)
		else $error("free-running host clock stopped");
	a_halt_stops: assert property (s_halt_held |-> !ctrl.host1_run)
		else $error("host clock kept running on stop input");
	a_agp_undef: assert property (ctrl.mn_mode |-> ctrl.agp_valid == (ctrl.agp_div != 4'h0))
		else $error("graphics divisor validity mismatch");
	a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl)
		else $error("data line pulled while serial clock high");
endmodule : cscr_top_chk

bind cscr_top cscr_top_chk #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) u_cscr_top_chk (.clk(clk),
	.rst_n(rst_n), .scl(scl), .sda_oe(sda_oe), .host_clock_halt_n(host_clock_halt_n),
	.ctrl(ctrl), .system_reset_n(system_reset_n));

// ---- test/cscr_i2c_host.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// serial host model
// ----------------------------------------
module cscr_i2c_host #(
	parameter logic [6:0] ADDR = 7'h4a,
	parameter int H = 11
) (
	output logic scl,
	output logic sda_lo,
	input wire logic sda
);
	logic lclk;
	// link clock with its own phase; scl only moves inside frames
	initial
	begin
		lclk = 0;
		scl = 1;
		sda_lo = 0;
		#1.7;
		forever #3 lclk = ~lclk;
	end
	task automatic tk();
		repeat (H) @(posedge lclk);
	endtask : tk
	// data moves a little after scl falls so the core never mistakes it for start or stop
	task automatic bitx(input logic b, output logic r);
		sda_lo = ~b;
		tk();
		scl = 1;
		tk();
		r = sda;
		scl = 0;
		repeat (2) @(posedge lclk);
	endtask : bitx
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(ai, ao);
	endtask : xfer
	task automatic start();
		sda_lo = 0;
		tk();
		scl = 1;
		tk();
		sda_lo = 1;
		tk();
		scl = 0;
		repeat (2) @(posedge lclk);
	endtask : start
	task automatic stop();
		sda_lo = 1;
		tk();
		scl = 1;
		tk();
		sda_lo = 0;
		tk();
	endtask : stop
	// address, command and count bytes, then registers from zero; nak counts refusals
	task automatic wr_frame(input logic [6:0] a, input logic [7:0] img [15], output logic [4:0] nak);
		logic [7:0] q;
		logic k;
		nak = 5'h00;
		start();
		for (int i = 0; i < 18; i++)
		begin
			xfer(i == 0 ? {a, 1'b0} : (i < 3 ? 8'h00 : img[i-3]), 1'b1, q, k);
			nak = nak + 5'(k);
		end
		stop();
	endtask : wr_frame
	task automatic rd_frame(output logic [7:0] rd [17]);
		logic [7:0] q;
		logic k;
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, k);
		for (int i = 0; i < 17; i++)
			xfer(8'hff, i == 16, rd[i], k);
		stop();
	endtask : rd_frame
endmodule : cscr_i2c_host

// ---- test/tb_cscr_top.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// testbench
// ----------------------------------------
module tb_cscr_top;
	localparam logic [7:0] IDL = cscr_pkg::ID_LOW;
	localparam logic [7:0] IDH = {cscr_pkg::ID_HIGH, cscr_pkg::VERSION};
	localparam logic [7:0] PU [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
		8'hb4, 8'hf5, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, IDL, IDH};
	localparam logic [7:0] EX [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h96, 8'h6b,
		8'hb7, 8'h95, 8'h00, 8'hc5, 8'h10, 8'h3c, 8'hd3, IDL, IDH};
	localparam logic [11:0] RT [16] = '{12'h225, 12'h235, 12'h333, 12'h334, 12'h335, 12'h344,
		12'h345, 12'h433, 12'h434, 12'h443, 12'h463, 12'h632, 12'h642, 12'h662, 12'h663, 12'h664};
	localparam logic [3:0] AT [8] = '{4'h3, 4'h5, 4'h6, 4'h8, 4'h4, 4'h0, 4'h0, 4'ha};
	localparam logic [2:0] AC [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	logic clk, rst_n, scl, host_lo, sda_w, sda_out, sda_oe, system_reset_n;
	logic [4:0] strap, halt, nak;
	cscr_pkg::cscr_ctrl_t ctrl;
	logic [7:0] img [15];
	logic [7:0] rd [17];
	int error_cnt, n_checks, falls, f0;
	realtime t_last, t_prev;
	// open-drain data line with pull-up
	assign sda_w = ~(host_lo | sda_oe);
	cscr_top #(.WD_SEC_CYCLES(50), .RST_PULSE_CYCLES(10)) u_cscr_top (.clk(clk), .rst_n(rst_n),
		.scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.graphics_select_strap(strap[4]), .freq_select_strap_3(strap[3]),
		.freq_select_strap_2(strap[2]), .freq_select_strap_1(strap[1]),
		.freq_select_strap_0(strap[0]), .graphics_clock_halt_n(halt[4]),
		.host_clock_halt_n(halt[3]), .local_bus_clock_halt_n(halt[2]),
		.memory_clock_halt_n(halt[1]), .power_down_n(halt[0]), .ctrl(ctrl),
		.system_reset_n(system_reset_n));
	cscr_i2c_host u_cscr_i2c_host (.scl(scl), .sda_lo(host_lo), .sda(sda_w));
	initial
	begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// spacing of watchdog pulses
	always @(negedge system_reset_n)
	begin
		falls++;
		t_prev = t_last;
		t_last = $realtime;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic do_reset();
		@(negedge clk);
		rst_n = 0;
		repeat (5) @(negedge clk);
		rst_n = 1;
		repeat (8) @(negedge clk);
	endtask : do_reset
	task automatic rd_cmp(input logic [7:0] ex [17]);
		u_cscr_i2c_host.rd_frame(rd);
		for (int i = 0; i < 17; i++)
			chk("register", ex[i], rd[i]);
	endtask : rd_cmp
	// hang guard: about 23 frames of 24 us each plus margin, under 100k cycles
	initial
	begin
		#700_000;
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		rst_n = 0;
		strap = 5'h16;
		halt = 5'h15;
		error_cnt = 0;
		n_checks = 0;
		falls = 0;
		do_reset();
		rd_cmp(PU);
		chk("halted host clock", 1'b0, ctrl.host1_run);
		chk("open drain level", 1'b0, sda_out);
		@(negedge clk);
		strap = 5'h09;
		// test bits kept at their power-up values, reserved places written too
		img = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h96, 8'h6b, 8'hff, 8'h80, 8'h40, 8'hc5,
			8'h10, 8'h3c, 8'hd3};
		u_cscr_i2c_host.wr_frame(7'h4a, img, nak);
		chk("acks", 5'h00, nak);
		chk("enables", 8'h96, {ctrl.gfx_en, ctrl.bus_en});
		chk("misc", 7'h37, {ctrl.sel_low_en, ctrl.fixed48_en, ctrl.intr_en, ctrl.sel_24,
			ctrl.intr_half, ctrl.ref_en});
		chk("skew", 3'h7, ctrl.skew);
		chk("free run", 1'b1, ctrl.host1_run);
		chk("m n test", {5'h05, 9'h110, 2'h2}, {ctrl.vco_m, ctrl.vco_n, ctrl.test});
		chk("spread", 8'h3c, {ctrl.spread_up, ctrl.spread_dn});
		chk("vco", 23'hc_0f51, ctrl.vco_khz);
		rd_cmp(EX);
		u_cscr_i2c_host.wr_frame(7'h4b, img, nak);
		chk("foreign address", 5'h12, nak);
		// every ratio code, every defined graphics code
		img[9] = 8'he0;
		for (int k = 0; k < 16; k++)
		begin
			img[14] = {1'b1, 4'(k), AC[k % 6]};
			u_cscr_i2c_host.wr_frame(7'h4a, img, nak);
			chk("ratios", RT[k], {ctrl.cpu_div, ctrl.sdram_div, ctrl.pci_div});
			chk("gfx ratio", {1'b1, AT[AC[k % 6]]}, {ctrl.agp_valid, ctrl.agp_div});
		end
		chk("stoppable", 1'b0, ctrl.host1_run);
		@(negedge clk);
		halt = 5'h1f;
		repeat (6) @(negedge clk);
		chk("released", 1'b1, ctrl.host1_run);
		// watchdog armed for two seconds
		img[14] = 8'h00;
		img[10] = 8'h82;
		u_cscr_i2c_host.wr_frame(7'h4a, img, nak);
		repeat (300) @(negedge clk);
		chk("pulse gap", 32'h0000_0320, 32'(int'(t_last - t_prev)));
		u_cscr_i2c_host.rd_frame(rd);
		chk("timeout flag", 8'hc2, rd[10]);
		chk("kept after pulse", 8'hb7, rd[8]);
		img[10] = 8'h02;
		u_cscr_i2c_host.wr_frame(7'h4a, img, nak);
		f0 = falls;
		repeat (300) @(negedge clk);
		chk("stopped timer", f0, falls);
		do_reset();
		chk("reset skew", 3'h4, ctrl.skew);
		tally_and_finish();
	end
endmodule : tb_cscr_top
